// File: hw/wlu_pkg.sv
// Constants shared by the word logic AND/OR unit and its result word store.
package wlu_pkg;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int WLU_WORD_W = 16;
	localparam int WLU_DWORD_W = 32;
	localparam int WLU_CODE_W = 10;
	localparam int WLU_ADDR_W = 8;
	localparam int WLU_DEPTH = 256;

	// ****************************************************************
	// Function codes
	// ****************************************************************
	localparam logic [WLU_CODE_W-1:0] WLU_CODE_WORD_AND = 10'h022;
	localparam logic [WLU_CODE_W-1:0] WLU_CODE_WORD_OR = 10'h023;
	localparam logic [WLU_CODE_W-1:0] WLU_CODE_DWORD_AND = 10'h262;
	localparam logic [WLU_CODE_W-1:0] WLU_CODE_DWORD_OR = 10'h263;

	// ****************************************************************
	// Reset values and field positions
	// ****************************************************************
	localparam logic [WLU_DWORD_W-1:0] WLU_RESULT_RST = 32'h0000_0000;
	localparam logic [WLU_WORD_W-1:0] WLU_WORD_RST = 16'h0000;
	localparam int WLU_WORD_MSB = 15;
	localparam int WLU_DWORD_MSB = 31;
	localparam logic [WLU_ADDR_W-1:0] WLU_ADDR_STEP = 8'h01;

endpackage

// File: hw/wlu_word_store.sv
// Destination word memory with two write ports and a registered read port.
`timescale 1ns/1ps
`default_nettype none

module wlu_word_store
	import wlu_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wr_lo_en,
	input wire logic [WLU_ADDR_W-1:0] wr_lo_addr,
	input wire logic [WLU_WORD_W-1:0] wr_lo_data,
	input wire logic wr_hi_en,
	input wire logic [WLU_ADDR_W-1:0] wr_hi_addr,
	input wire logic [WLU_WORD_W-1:0] wr_hi_data,
	input wire logic [WLU_ADDR_W-1:0] rd_addr,
	output logic [WLU_WORD_W-1:0] rd_data
);

	logic [WLU_WORD_W-1:0] mem_reg [WLU_DEPTH];
	logic [WLU_WORD_W-1:0] rd_data_reg;

	// The upper half wins a clash, though the two addresses never meet for a pair.
	genvar gi;
	generate
		for (gi = 0; gi < WLU_DEPTH; gi++) begin : g_word
			always_ff @(posedge clock) begin
				if (wr_hi_en && wr_hi_addr == WLU_ADDR_W'(gi)) begin
					mem_reg[gi] <= wr_hi_data;
				end else if (wr_lo_en && wr_lo_addr == WLU_ADDR_W'(gi)) begin
					mem_reg[gi] <= wr_lo_data;
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_reg <= WLU_WORD_RST;
		end else begin
			rd_data_reg <= mem_reg[rd_addr];
		end
	end

	assign rd_data = rd_data_reg;

endmodule
`default_nettype wire

// File: hw/wlu_unit.sv
// Word logic AND/OR execution unit: operations, condition flags and result store.
// Function
// RULE1: Code 034 ANDs two 16-bit operands into the destination word.
// RULE2: Code 610 ANDs two 32-bit operands into a destination word pair.
// RULE3: Code 035 ORs two 16-bit operands into the destination word.
// RULE4: Code 611 ORs two 32-bit operands into a destination word pair.
// RULE5: Double AND reads word and next word, writes destination and next word.
// RULE6: Double OR uses consecutive word pairs, stores two consecutive destination words.
// RULE7: Single AND bit is 1 only when both input bits are 1.
// RULE8: Single OR bit is 0 only when both input bits are 0.
// RULE9: Equals flag set on zero result, error flag always cleared.
// RULE10: Negative flag follows the result's most significant bit.
// RULE11: Sequencer raises condition; unit executes every cycle it is true.
// RULE12: Differentiated variant executes only on condition's false-to-true change.
`timescale 1ns/1ps
`default_nettype none

module wlu_unit
	import wlu_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic exec_cond,
	input wire logic diff_mode,
	input wire logic [WLU_CODE_W-1:0] func_code,
	input wire logic [WLU_WORD_W-1:0] opnd1_lo,
	input wire logic [WLU_WORD_W-1:0] opnd1_hi,
	input wire logic [WLU_WORD_W-1:0] opnd2_lo,
	input wire logic [WLU_WORD_W-1:0] opnd2_hi,
	input wire logic [WLU_ADDR_W-1:0] dest_addr,
	input wire logic [WLU_ADDR_W-1:0] rd_addr,
	output logic [WLU_WORD_W-1:0] rd_data,
	output logic [WLU_DWORD_W-1:0] result,
	output logic done,
	output logic error_flag,
	output logic equals_flag,
	output logic negative_flag
);

	// ****************************************************************
	// Code decoding
	// ****************************************************************
	function automatic logic code_is_legal(input logic [WLU_CODE_W-1:0] c);
		return (c == WLU_CODE_WORD_AND) || (c == WLU_CODE_WORD_OR) ||
			(c == WLU_CODE_DWORD_AND) || (c == WLU_CODE_DWORD_OR);
	endfunction

	function automatic logic code_is_dword(input logic [WLU_CODE_W-1:0] c);
		return (c == WLU_CODE_DWORD_AND) || (c == WLU_CODE_DWORD_OR);
	endfunction

	function automatic logic code_is_or(input logic [WLU_CODE_W-1:0] c);
		return (c == WLU_CODE_WORD_OR) || (c == WLU_CODE_DWORD_OR);
	endfunction

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rst_meta_reg;
	logic rst_n;

	// Assertion is immediate, release waits two edges to stay clear of recovery time.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// ****************************************************************
	// Execution condition
	// ****************************************************************
	logic exec_prev_reg;
	logic exec_prev_next;
	logic fire;
	logic legal;
	logic dword;

	always_comb begin
		exec_prev_next = exec_cond;
		legal = code_is_legal(func_code);
		dword = code_is_dword(func_code);
		// The plain form repeats every cycle; the differentiated form only on a rise.
		if (diff_mode) begin
			fire = exec_cond && !exec_prev_reg && legal; // RULE12
		end else begin
			fire = exec_cond && legal; // RULE11
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			exec_prev_reg <= 1'b0;
		end else begin
			exec_prev_reg <= exec_prev_next;
		end
	end

	// ****************************************************************
	// Datapath and flags
	// ****************************************************************
	logic [WLU_DWORD_W-1:0] op_a;
	logic [WLU_DWORD_W-1:0] op_b;
	logic [WLU_DWORD_W-1:0] res_calc;
	logic [WLU_DWORD_W-1:0] result_reg;
	logic [WLU_DWORD_W-1:0] result_next;
	logic done_reg;
	logic done_next;
	logic equals_reg;
	logic equals_next;
	logic negative_reg;
	logic negative_next;
	logic dword_reg;
	logic dword_next;
	logic error_reg;
	logic error_next;

	always_comb begin
		// Single-word codes ignore the upper operand words entirely.
		op_a = dword ? {opnd1_hi, opnd1_lo} : {WLU_WORD_RST, opnd1_lo}; // RULE5 RULE6
		op_b = dword ? {opnd2_hi, opnd2_lo} : {WLU_WORD_RST, opnd2_lo}; // RULE5 RULE6
		if (code_is_or(func_code)) begin
			res_calc = op_a | op_b; // RULE3 RULE4 RULE8
		end else begin
			res_calc = op_a & op_b; // RULE1 RULE2 RULE7
		end
		result_next = result_reg;
		equals_next = equals_reg;
		negative_next = negative_reg;
		dword_next = dword_reg;
		done_next = fire;
		// None of these operations can fail, so the error flag never rises.
		error_next = 1'b0; // RULE9
		// Flags keep their value when nothing executes.
		if (fire) begin
			result_next = res_calc;
			equals_next = (res_calc == WLU_RESULT_RST); // RULE9
			negative_next = dword ? res_calc[WLU_DWORD_MSB] : res_calc[WLU_WORD_MSB]; // RULE10
			dword_next = dword;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= WLU_RESULT_RST;
			done_reg <= 1'b0;
			equals_reg <= 1'b0;
			negative_reg <= 1'b0;
			dword_reg <= 1'b0;
			error_reg <= 1'b0;
		end else begin
			result_reg <= result_next;
			done_reg <= done_next;
			equals_reg <= equals_next;
			negative_reg <= negative_next;
			dword_reg <= dword_next;
			error_reg <= error_next;
		end
	end

	assign result = result_reg;
	assign done = done_reg;
	assign equals_flag = equals_reg;
	assign negative_flag = negative_reg;
	assign error_flag = error_reg;

	// ****************************************************************
	// Destination store
	// ****************************************************************
	logic wr_hi_en;
	logic [WLU_ADDR_W-1:0] wr_hi_addr;

	always_comb begin
		wr_hi_en = fire && dword; // RULE5 RULE6
		wr_hi_addr = dest_addr + WLU_ADDR_STEP; // RULE5 RULE6
	end

	wlu_word_store u_store (
		.clock(clock),
		.rst_n(rst_n),
		.wr_lo_en(fire),
		.wr_lo_addr(dest_addr),
		.wr_lo_data(res_calc[WLU_WORD_W-1:0]),
		.wr_hi_en(wr_hi_en),
		.wr_hi_addr(wr_hi_addr),
		.wr_hi_data(res_calc[WLU_DWORD_W-1:WLU_WORD_W]),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_fire_code(logic [WLU_CODE_W-1:0] c);
		fire && func_code == c;
	endsequence

	// ****************************************************************
	// Result assertions
	// ****************************************************************
	a_word_and: assert property (s_fire_code(WLU_CODE_WORD_AND) |=> // RULE1 RULE7
		result == {WLU_WORD_RST, $past(opnd1_lo) & $past(opnd2_lo)})
		else $error("word AND result wrong");

	a_dword_and: assert property (s_fire_code(WLU_CODE_DWORD_AND) |=> // RULE2
		result == ({$past(opnd1_hi), $past(opnd1_lo)} & {$past(opnd2_hi), $past(opnd2_lo)}))
		else $error("double AND result wrong");

	a_word_or: assert property (s_fire_code(WLU_CODE_WORD_OR) |=> // RULE3 RULE8
		result == {WLU_WORD_RST, $past(opnd1_lo) | $past(opnd2_lo)})
		else $error("word OR result wrong");

	a_dword_or: assert property (s_fire_code(WLU_CODE_DWORD_OR) |=> // RULE4
		result == ({$past(opnd1_hi), $past(opnd1_lo)} | {$past(opnd2_hi), $past(opnd2_lo)}))
		else $error("double OR result wrong");

	a_single_upper: assert property (done && !dword_reg |-> // RULE1 RULE3
		result[WLU_DWORD_W-1:WLU_WORD_W] == WLU_WORD_RST)
		else $error("single-word result has upper bits set");

	// ****************************************************************
	// Store assertions
	// ****************************************************************
	a_pair_store: assert property (fire && code_is_dword(func_code) |-> // RULE5 RULE6
		wr_hi_en && wr_hi_addr == dest_addr + WLU_ADDR_STEP)
		else $error("double result upper word not stored at next address");

	a_single_store: assert property (fire && !code_is_dword(func_code) |-> !wr_hi_en) // RULE1 RULE3
		else $error("single-word operation wrote a second word");

	a_pair_and_data: assert property (s_fire_code(WLU_CODE_DWORD_AND) |-> // RULE5
		res_calc == {opnd1_hi & opnd2_hi, opnd1_lo & opnd2_lo})
		else $error("double AND words not paired into the store");

	a_pair_or_data: assert property (s_fire_code(WLU_CODE_DWORD_OR) |-> // RULE6
		res_calc == {opnd1_hi | opnd2_hi, opnd1_lo | opnd2_lo})
		else $error("double OR words not paired into the store");

	// ****************************************************************
	// Flag assertions
	// ****************************************************************
	a_equals_flag: assert property (done |-> // RULE9
		(equals_flag == (result == WLU_RESULT_RST)) && !error_flag)
		else $error("equals or error flag wrong after operation");

	a_negative_flag: assert property (done |-> // RULE10
		negative_flag == (dword_reg ? result[WLU_DWORD_MSB] : result[WLU_WORD_MSB]))
		else $error("negative flag does not follow result top bit");

	a_error_low: assert property (!error_flag) // RULE9
		else $error("error flag raised");

	a_flags_hold: assert property (!fire |=> // RULE9 RULE10
		$stable(equals_flag) && $stable(negative_flag))
		else $error("condition flags changed without execution");

	a_zero_positive: assert property (done && equals_flag |-> !negative_flag) // RULE9 RULE10
		else $error("zero result flagged as negative");

	// ****************************************************************
	// Execution assertions
	// ****************************************************************
	a_level_exec: assert property (exec_cond && !diff_mode && // RULE11
		code_is_legal(func_code) |=> done)
		else $error("operation not executed while condition true");

	a_illegal_quiet: assert property (exec_cond && // RULE11
		!code_is_legal(func_code) |=> !done)
		else $error("illegal function code executed");

	a_done_cause: assert property (done |-> // RULE11
		$past(exec_cond) && $past(code_is_legal(func_code)))
		else $error("done raised without a legal request");

	// A condition held through reset also counts as a rise, since the history flop clears.
	sequence s_cond_rise;
		!exec_cond ##1 exec_cond && diff_mode && code_is_legal(func_code);
	endsequence

	a_diff_rise: assert property (s_cond_rise |=> done) // RULE12
		else $error("differentiated operation missed the condition rise");

	sequence s_held_cond;
		exec_cond ##1 exec_cond && diff_mode;
	endsequence

	a_diff_once: assert property (s_held_cond |=> !done) // RULE12
		else $error("differentiated operation repeated while condition held");

	a_diff_hold: assert property (s_held_cond |=> $stable(result)) // RULE12
		else $error("differentiated operation changed result while condition held");

	a_hold_idle: assert property (!fire |=> $stable(result) && !done) // RULE11
		else $error("result changed without execution");

endmodule
`default_nettype wire

// File: tb/wlu_seq_model.sv
// Instruction sequencer model driving the unit's execution interface.
`timescale 1ns/1ps
`default_nettype none

module wlu_seq_model
	import wlu_pkg::*;
(
	input wire logic clock,
	output logic exec_cond,
	output logic diff_mode,
	output logic [WLU_CODE_W-1:0] func_code,
	output logic [WLU_WORD_W-1:0] opnd1_lo,
	output logic [WLU_WORD_W-1:0] opnd1_hi,
	output logic [WLU_WORD_W-1:0] opnd2_lo,
	output logic [WLU_WORD_W-1:0] opnd2_hi,
	output logic [WLU_ADDR_W-1:0] dest_addr,
	output logic [WLU_ADDR_W-1:0] rd_addr
);
	initial begin
		exec_cond = 1'b0;
		diff_mode = 1'b0;
		func_code = 10'h000;
		{opnd1_hi, opnd1_lo, opnd2_hi, opnd2_lo} = 64'h0;
		dest_addr = 8'h00;
		rd_addr = 8'h00;
	end

	// ****************************************************************
	// Requests change only just after a falling edge
	// ****************************************************************
	task automatic issue(input logic [WLU_CODE_W-1:0] c, input logic [31:0] a,
		input logic [31:0] b, input logic [WLU_ADDR_W-1:0] d, input logic df);
		@(negedge clock);
		func_code = c;
		{opnd1_hi, opnd1_lo} = a;
		{opnd2_hi, opnd2_lo} = b;
		dest_addr = d;
		diff_mode = df;
		exec_cond = 1'b1;
	endtask

	// Idle operands flip so that stale values can never pass for a result.
	task automatic idle(input logic [WLU_ADDR_W-1:0] ra);
		@(negedge clock);
		exec_cond = 1'b0;
		{opnd1_hi, opnd1_lo, opnd2_hi, opnd2_lo} = ~{opnd1_hi, opnd1_lo, opnd2_hi, opnd2_lo};
		rd_addr = ra;
	endtask
endmodule

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the word logic AND/OR unit.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import wlu_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic exec_cond, diff_mode, done, error_flag, equals_flag, negative_flag;
	logic [WLU_CODE_W-1:0] func_code;
	logic [WLU_WORD_W-1:0] opnd1_lo, opnd1_hi, opnd2_lo, opnd2_hi, rd_data;
	logic [WLU_ADDR_W-1:0] dest_addr, rd_addr;
	logic [WLU_DWORD_W-1:0] result;
	int fails = 0;
	int n_compared = 0;

	always #2.5 clock = ~clock;

	wlu_seq_model i_wlu_seq_model (.clock, .exec_cond, .diff_mode, .func_code, .opnd1_lo,
		.opnd1_hi, .opnd2_lo, .opnd2_hi, .dest_addr, .rd_addr);
	wlu_unit i_wlu_unit (.clock, .arst_n, .exec_cond, .diff_mode, .func_code, .opnd1_lo,
		.opnd1_hi, .opnd2_lo, .opnd2_hi, .dest_addr, .rd_addr, .rd_data, .result, .done,
		.error_flag, .equals_flag, .negative_flag);

	// ****************************************************************
	// Shared helpers
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic step;
		@(posedge clock);
		#1;
	endtask

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_op(input logic [WLU_CODE_W-1:0] c, input logic [31:0] a,
		input logic [31:0] b, input logic [WLU_ADDR_W-1:0] d);
		logic dbl;
		logic [31:0] e;
		dbl = (c === WLU_CODE_DWORD_AND) || (c === WLU_CODE_DWORD_OR);
		e = (c === WLU_CODE_WORD_AND || c === WLU_CODE_DWORD_AND) ? a & b : a | b;
		if (!dbl) begin
			e[31:16] = 16'h0000;
		end
		i_wlu_seq_model.issue(c, a, b, d, 1'b0);
		step();
		chk(done, 1'b1);
		chk(result, e);
		chk(equals_flag, e == 32'h0);
		chk(error_flag, 1'b0);
		chk(negative_flag, dbl ? e[31] : e[15]);
		i_wlu_seq_model.idle(d);
		step();
		chk(rd_data, e[15:0]);
		if (dbl) begin
			i_wlu_seq_model.idle(d + 8'h01);
			step();
			chk(rd_data, e[31:16]);
		end
	endtask

	// Condition held high with back-to-back operands executes each cycle.
	task automatic t_level;
		i_wlu_seq_model.issue(WLU_CODE_WORD_AND, 32'h0, 32'h0000_00f0, 8'h10, 1'b0);
		step();
		i_wlu_seq_model.issue(WLU_CODE_WORD_OR, 32'h0, 32'h0000_00f0, 8'h11, 1'b0);
		step();
		chk(done, 1'b1);
		chk(result, 32'h0000_00f0);
		i_wlu_seq_model.idle(8'h11);
		step();
		chk(done, 1'b0);
		chk(rd_data, 16'h00f0);
	endtask

	// Differentiated variant acts on the rise only, then again after a drop.
	task automatic t_diff;
		i_wlu_seq_model.issue(WLU_CODE_WORD_OR, 32'h0, 32'h0000_0005, 8'h20, 1'b1);
		step();
		chk(done, 1'b1);
		i_wlu_seq_model.issue(WLU_CODE_WORD_OR, 32'h0, 32'h0000_0009, 8'h20, 1'b1);
		step();
		chk(done, 1'b0);
		chk(result, 32'h0000_0005);
		i_wlu_seq_model.idle(8'h20);
		step();
		i_wlu_seq_model.issue(WLU_CODE_WORD_OR, 32'h0, 32'h0000_0009, 8'h20, 1'b1);
		step();
		chk(done, 1'b1);
		chk(result, 32'h0000_0009);
		i_wlu_seq_model.idle(8'h20);
	endtask

	task automatic t_bad;
		i_wlu_seq_model.issue(10'h3ff, 32'hffff_ffff, 32'hffff_ffff, 8'h20, 1'b0);
		step();
		chk(done, 1'b0);
		chk(result, 32'h0000_0009);
		i_wlu_seq_model.idle(8'h20);
		step();
		chk(rd_data, 16'h0009);
	endtask

	initial begin
		repeat (4) @(posedge clock);
		chk({result[0], done, equals_flag, negative_flag, error_flag}, 32'h0);
		@(negedge clock);
		arst_n = 1'b1;
		repeat (3) @(posedge clock);
		t_op(WLU_CODE_WORD_AND, 32'hffff_c3a5, 32'h0000_8181, 8'h01);
		t_op(WLU_CODE_WORD_OR, 32'hffff_0000, 32'hffff_0000, 8'h02);
		t_op(WLU_CODE_DWORD_AND, 32'h0f0f_1234, 32'hffff_ff00, 8'hff);
		t_op(WLU_CODE_DWORD_AND, 32'h1234_0000, 32'h0000_ffff, 8'h04);
		t_op(WLU_CODE_DWORD_OR, 32'h8000_0000, 32'h0000_0001, 8'h06);
		t_level();
		t_diff();
		t_bad();
		close_out();
	end

	initial begin
		#10000;
		fails++;
		close_out();
	end
endmodule

`default_nettype wire
